/* File: npm_pkg.sv */
// shared constants and types for the tag power-mode sequencer
`default_nettype none
package npm_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned WAKE_MIN_NS = 10000;
    localparam int unsigned WAKE_MIN_CYC = (WAKE_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned INIT_DLY_NS = 100000;
    localparam int unsigned INIT_DLY_CYC = (INIT_DLY_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned IF_SEL_NS = 250;
    localparam int unsigned IF_SEL_CYC = (IF_SEL_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int unsigned FAST_OSC_MS = 10;
    localparam int unsigned FAST_OSC_CYC = FAST_OSC_MS * (CLK_HZ / 1000);
    localparam logic [7:0] CTL_SEND = 8'h00;
    localparam logic [7:0] CTL_RESET = 8'h01;
    localparam logic [7:0] CTL_READ = 8'h02;
    localparam logic [7:0] CTL_POLL = 8'h03;
    localparam logic [1:0] IF_SEL_SPI = 2'h1;
    localparam logic [1:0] WAKE_SRC_PIN = 2'h1;
    localparam logic [1:0] WAKE_SRC_FIELD = 2'h2;
    typedef enum logic [2:0] {
        NPM_POWER_UP,
        NPM_HIBERNATE,
        NPM_SLEEP,
        NPM_READY,
        NPM_TAG_EMU
    } npm_state_e;
    // host command to the mode logic, the parsed form of an idle or protocol request
    typedef enum logic [2:0] {
        NPM_CMD_NONE,
        NPM_CMD_HIBERNATE,
        NPM_CMD_SLEEP,
        NPM_CMD_CHOOSE_PROTOCOL,
        NPM_CMD_END_EMU
    } npm_cmd_e;
endpackage
`default_nettype wire

/* File: npm_link_if.sv */
// pins between host and sequencer
`timescale 1ns/1ps
`default_nettype none
interface npm_link_if;
    logic wake_n;
    logic spi_ss_n;
    logic spi_sck;
    logic spi_mosi;
    logic spi_miso;
    logic spi_miso_oe_n;
    logic irq_out_n;
    logic host_if_select_0;
    logic host_if_select_1;
    modport device (input wake_n, spi_ss_n, spi_sck, spi_mosi, host_if_select_0, host_if_select_1,
                    output spi_miso, spi_miso_oe_n, irq_out_n);
    modport host (output wake_n, spi_ss_n, spi_sck, spi_mosi, host_if_select_0, host_if_select_1,
                  input spi_miso, spi_miso_oe_n, irq_out_n);
endinterface
`default_nettype wire

/* File: npm_device.sv */
// device end: power-mode sequencer with spi control-byte front end
`timescale 1ns/1ps
`default_nettype none
module npm_device
    import npm_pkg::*;
#(
    parameter int unsigned WAKE_CYC = WAKE_MIN_CYC,
    parameter int unsigned OSC_CYC = FAST_OSC_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // link pins
    npm_link_if.device link,
    // core side
    input wire npm_cmd_e core_cmd,
    input wire logic [1:0] core_wake_src,
    input wire logic field_detect,
    input wire logic reply_ready,
    output npm_state_e mode_state,
    output logic slow_oscillator,
    output logic fast_oscillator,
    output logic [1:0] host_if_sel,
    output logic spi_enabled,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic read_started
);
    logic [1:0] wake_sync_reg, ss_sync_reg, sck_sync_reg, mosi_sync_reg, fld_sync_reg;
    logic wake_d_reg, ss_d_reg, sck_d_reg;
    logic [15:0] low_cnt_reg;
    logic [$clog2(OSC_CYC + 1)-1:0] osc_cnt_reg;
    logic wake_ok, wake_fall, sck_rise, ss_rise, ss_fall;
    logic if_latched_reg, latch_pend_reg, reset_pend_reg, first_byte_reg, reply_pend_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] ctl_reg;
    logic osc_wait_reg;
    logic [3:0] sel_sync_reg;
    npm_state_e state_reg;

    // pins from the far side pass two flops; stage one feeds only stage two
    always_ff @(posedge sys_clk) begin
        wake_sync_reg <= {wake_sync_reg[0], link.wake_n};
        ss_sync_reg <= {ss_sync_reg[0], link.spi_ss_n};
        sck_sync_reg <= {sck_sync_reg[0], link.spi_sck};
        mosi_sync_reg <= {mosi_sync_reg[0], link.spi_mosi};
        fld_sync_reg <= {fld_sync_reg[0], field_detect};
        sel_sync_reg <= {sel_sync_reg[1:0], link.host_if_select_1, link.host_if_select_0};
        wake_d_reg <= wake_sync_reg[1];
        ss_d_reg <= ss_sync_reg[1];
        sck_d_reg <= sck_sync_reg[1];
    end

    assign wake_fall = wake_d_reg & ~wake_sync_reg[1];
    assign sck_rise = ~sck_d_reg & sck_sync_reg[1];
    assign ss_rise = ~ss_d_reg & ss_sync_reg[1];
    assign ss_fall = ss_d_reg & ~ss_sync_reg[1];

    // low-width filter on the wake pin
    always_ff @(posedge sys_clk) begin
        if (reset || wake_sync_reg[1]) begin
            low_cnt_reg <= 16'h0000;
        end else if (low_cnt_reg != 16'hffff) begin
            low_cnt_reg <= low_cnt_reg + 16'h0001;
        end
    end
    // one pulse when the low level just passed the width; shorter pulses never fire
    assign wake_ok = (low_cnt_reg == 16'(WAKE_CYC));

    // interface select latched on the first wake fall out of reset or hibernate
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            latch_pend_reg <= 1'b1;
            if_latched_reg <= 1'b0;
            host_if_sel <= 2'h0;
        end else begin
            if (state_reg == NPM_HIBERNATE && !latch_pend_reg) begin
                latch_pend_reg <= 1'b1;
            end else if (latch_pend_reg && wake_fall) begin
                // sampled a few cycles after the edge, well inside the selection time
                host_if_sel <= sel_sync_reg[3:2];
                if_latched_reg <= 1'b1;
                latch_pend_reg <= 1'b0;
            end
        end
    end

    // mode sequencer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= NPM_POWER_UP;
            osc_wait_reg <= 1'b0;
            osc_cnt_reg <= '0;
        end else if (reset_pend_reg && ss_rise) begin
            state_reg <= NPM_POWER_UP;
            osc_wait_reg <= 1'b0;
            osc_cnt_reg <= '0;
        end else if (osc_wait_reg) begin
            // fast oscillator settling before ready
            if (osc_cnt_reg == ($clog2(OSC_CYC + 1))'(OSC_CYC - 1)) begin
                osc_wait_reg <= 1'b0;
                state_reg <= NPM_READY;
            end else begin
                osc_cnt_reg <= osc_cnt_reg + 1'b1;
            end
        end else begin
            case (state_reg)
                NPM_POWER_UP, NPM_HIBERNATE: begin
                    if (wake_ok) begin
                        osc_wait_reg <= 1'b1;
                        osc_cnt_reg <= '0;
                    end
                end
                NPM_SLEEP: begin
                    if ((wake_ok && core_wake_src[0]) || (fld_sync_reg[1] && core_wake_src[1])) begin
                        osc_wait_reg <= 1'b1;
                        osc_cnt_reg <= '0;
                    end
                end
                NPM_READY, NPM_TAG_EMU: begin
                    // low-power states only on explicit command
                    if (core_cmd == NPM_CMD_HIBERNATE) begin
                        state_reg <= NPM_HIBERNATE;
                    end else if (core_cmd == NPM_CMD_SLEEP) begin
                        state_reg <= NPM_SLEEP;
                    end else if (core_cmd == NPM_CMD_CHOOSE_PROTOCOL) begin
                        state_reg <= NPM_TAG_EMU;
                    end else if (core_cmd == NPM_CMD_END_EMU) begin
                        state_reg <= NPM_READY;
                    end
                end
                default: state_reg <= NPM_POWER_UP;
            endcase
        end
    end

    assign mode_state = state_reg;
    assign slow_oscillator = (state_reg == NPM_POWER_UP) || (state_reg == NPM_SLEEP);
    assign fast_oscillator = osc_wait_reg || (state_reg == NPM_READY) || (state_reg == NPM_TAG_EMU);
    // spi live only in active states once an interface select value has been latched, whatever its value
    assign spi_enabled = if_latched_reg && !osc_wait_reg &&
                         ((state_reg == NPM_READY) || (state_reg == NPM_TAG_EMU));

    // spi byte receiver, mode 0, msb first; bytes ignored while select high
    always_ff @(posedge sys_clk) begin
        if (reset || ss_sync_reg[1] || !spi_enabled) begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            rx_valid <= 1'b0;
            first_byte_reg <= 1'b1;
        end else begin
            rx_valid <= 1'b0;
            if (sck_rise) begin
                shift_reg <= {shift_reg[6:0], mosi_sync_reg[1]};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    rx_byte <= {shift_reg[6:0], mosi_sync_reg[1]};
                    rx_valid <= 1'b1;
                end
            end
            // cleared a cycle late so the capture below still sees the control byte
            if (rx_valid) begin
                first_byte_reg <= 1'b0;
            end
        end
    end

    // control byte capture and deferred reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctl_reg <= 8'hff;
            reset_pend_reg <= 1'b0;
        end else begin
            if (rx_valid && first_byte_reg) begin
                ctl_reg <= rx_byte;
            end
            if (ss_fall) begin
                ctl_reg <= 8'hff;
            end
            // reset waits for select to return high
            // armed once per control byte, so a stale code cannot fire at a later select rise
            if (ss_rise) begin
                reset_pend_reg <= 1'b0;
            end
            if (rx_valid && first_byte_reg && rx_byte == CTL_RESET) begin
                reset_pend_reg <= 1'b1;
            end
        end
    end
    assign read_started = (ctl_reg == CTL_READ);

    // interrupt low from reply ready until select rises at the end of a read frame
    always_ff @(posedge sys_clk) begin
        if (reset || !spi_enabled) begin
            reply_pend_reg <= 1'b0;
        end else if (reply_ready) begin
            reply_pend_reg <= 1'b1;
        end else if (read_started && ss_rise) begin
            reply_pend_reg <= 1'b0;
        end
    end
    assign link.irq_out_n = ~reply_pend_reg;

    // miso: flag byte during poll, else zero; enable low only while selected
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            link.spi_miso <= 1'b0;
        end else begin
            link.spi_miso <= (ctl_reg == CTL_POLL) ? ((bit_cnt_reg == 3'h4) && reply_pend_reg) ||
                             ((bit_cnt_reg == 3'h5) && !reply_pend_reg) : 1'b0;
        end
    end
    assign link.spi_miso_oe_n = ss_sync_reg[1] | ~spi_enabled;
endmodule
`default_nettype wire

/* File: npm_host.sv */
// host end: drives the wake pulse and spi control bytes
`timescale 1ns/1ps
`default_nettype none
module npm_host
    import npm_pkg::*;
#(
    parameter int unsigned INIT_CYC = INIT_DLY_CYC,
    parameter int unsigned WAKE_CYC = WAKE_MIN_CYC,
    parameter int unsigned SCK_DIV = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // link pins
    npm_link_if.host link,
    // user side
    input wire logic wake_req,
    input wire logic byte_req,
    input wire logic [7:0] byte_data,
    input wire logic end_frame,
    output logic busy,
    output logic powered_wait_done,
    output logic irq_pending
);
    typedef enum logic [2:0] {H_IDLE, H_WAKE, H_SEL, H_SHIFT, H_DESEL} npm_hst_e;
    npm_hst_e st_reg;
    logic [31:0] cnt_reg;
    logic [7:0] tx_reg;
    logic [3:0] bit_reg;
    logic [1:0] irq_sync_reg;

    // irq pin from the other party synchronised before use
    always_ff @(posedge sys_clk) begin
        irq_sync_reg <= {irq_sync_reg[0], link.irq_out_n};
    end
    assign irq_pending = ~irq_sync_reg[1];

    // supply settle wait before wake is allowed
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            powered_wait_done <= 1'b0;
        end else if (st_reg == H_IDLE && cnt_reg == INIT_CYC) begin
            powered_wait_done <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= H_IDLE;
            cnt_reg <= 32'h0;
            link.wake_n <= 1'b1;
            link.spi_ss_n <= 1'b1;
            link.spi_sck <= 1'b0;
            link.spi_mosi <= 1'b0;
            tx_reg <= 8'h00;
            bit_reg <= 4'h0;
        end else begin
            case (st_reg)
                H_IDLE: begin
                    if (!powered_wait_done) begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end else if (wake_req) begin
                        link.wake_n <= 1'b0;
                        cnt_reg <= 32'h0;
                        st_reg <= H_WAKE;
                    end else if (byte_req) begin
                        link.spi_ss_n <= 1'b0;
                        tx_reg <= byte_data;
                        bit_reg <= 4'h0;
                        cnt_reg <= 32'h0;
                        st_reg <= H_SHIFT;
                    end else if (end_frame && !link.spi_ss_n) begin
                        st_reg <= H_DESEL;
                    end
                end
                H_WAKE: begin
                    // two margin cycles past the minimum width; wake is held low for WAKE_CYC + 2 cycles
                    if (cnt_reg == WAKE_CYC + 1) begin
                        link.wake_n <= 1'b1;
                        st_reg <= H_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end
                end
                H_SHIFT: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg == 32'h0) begin
                        link.spi_mosi <= tx_reg[7];
                    end else if (cnt_reg == SCK_DIV) begin
                        link.spi_sck <= 1'b1;
                    end else if (cnt_reg == 2 * SCK_DIV) begin
                        link.spi_sck <= 1'b0;
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        bit_reg <= bit_reg + 4'h1;
                        cnt_reg <= 32'h0;
                        if (bit_reg == 4'h7) begin
                            st_reg <= H_SEL;
                        end
                    end
                end
                H_SEL: st_reg <= H_IDLE;
                H_DESEL: begin
                    link.spi_ss_n <= 1'b1;
                    st_reg <= H_IDLE;
                end
                default: st_reg <= H_IDLE;
            endcase
        end
    end
    assign busy = (st_reg != H_IDLE) || !powered_wait_done;
    assign link.host_if_select_0 = IF_SEL_SPI[0];
    assign link.host_if_select_1 = IF_SEL_SPI[1];
endmodule
`default_nettype wire

/* File: npm_link_props.sv */
// concurrent checks on the host-device link of the power-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module npm_link_props
    import npm_pkg::*;
#(
    parameter int OSC_CYC = 50
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // link pins
    input wire logic wake_n,
    input wire logic spi_ss_n,
    input wire logic spi_miso_oe_n,
    input wire logic irq_out_n,
    // device state
    input wire npm_state_e mode_state,
    input wire logic slow_oscillator,
    input wire logic fast_oscillator,
    input wire logic spi_enabled,
    input wire logic [1:0] host_if_sel
);
    localparam int OSC_LIM = OSC_CYC + 8;
    localparam int SEL_LIM = 10;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence wake_start_s;
        $fell(wake_n) && mode_state == NPM_POWER_UP;
    endsequence
    // five idle cycles let the select synchroniser settle
    sequence irq_idle_s;
        (!irq_out_n && spi_ss_n) [*5];
    endsequence
    chk_fresh_power_up: assert property ($fell(reset) |-> mode_state == NPM_POWER_UP && slow_oscillator)
        else $error("mode after reset is not power-up");
    chk_wake_not_early: assert property (wake_start_s |-> !fast_oscillator [*8])
        else $error("woke before the qualifying width");
    chk_wait_silent: assert property (mode_state inside {NPM_POWER_UP, NPM_HIBERNATE, NPM_SLEEP}
        |-> spi_miso_oe_n && !spi_enabled)
        else $error("spi active in a wait state");
    chk_slow_osc_on: assert property (mode_state inside {NPM_POWER_UP, NPM_SLEEP} |-> slow_oscillator)
        else $error("slow oscillator off in wait state");
    chk_ready_spi_on: assert property (mode_state == NPM_READY |-> fast_oscillator && spi_enabled)
        else $error("ready without fast clock or spi");
    chk_wait_by_cmd: assert property ($changed(mode_state) && mode_state inside {NPM_HIBERNATE, NPM_SLEEP}
        |-> $past(mode_state) inside {NPM_READY, NPM_TAG_EMU})
        else $error("wait state entered from a wait state");
    chk_osc_to_ready: assert property ($rose(fast_oscillator) |-> ##[1:OSC_LIM] mode_state == NPM_READY)
        else $error("ready late after fast oscillator start");
    chk_if_sel_time: assert property (wake_start_s |-> ##[1:SEL_LIM] host_if_sel == IF_SEL_SPI)
        else $error("interface not selected in time");
    // the two-flop select synchroniser delays the release by two cycles
    chk_miso_unsel: assert property (spi_ss_n && $past(spi_ss_n) && $past(spi_ss_n, 2) |-> spi_miso_oe_n)
        else $error("miso driven while not selected");
    chk_irq_stays: assert property (irq_idle_s |=> !irq_out_n)
        else $error("interrupt released without a read");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench: host and device ends joined on one link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import npm_pkg::*;
    localparam int DEV_WAKE = 8;
    localparam int DEV_OSC = 50;
    logic sys_clk;
    logic reset;
    npm_cmd_e core_cmd;
    logic [1:0] core_wake_src;
    logic field_detect;
    logic reply_ready;
    logic wake_req;
    logic byte_req;
    logic [7:0] byte_data;
    logic end_frame;
    logic busy;
    logic powered_wait_done;
    logic irq_pending;
    npm_state_e mode_state;
    npm_state_e mode_b;
    logic slow_oscillator;
    logic fast_oscillator;
    logic spi_enabled;
    logic rx_valid;
    logic read_started;
    logic [1:0] host_if_sel;
    logic [7:0] rx_byte;
    logic [7:0] miso_cap;
    int fail_count = 0;
    int n_checks = 0;
    int rx_count = 0;
    npm_link_if link();
    npm_link_if link_b();
    npm_device #(.WAKE_CYC(DEV_WAKE), .OSC_CYC(DEV_OSC)) u_npm_device (.sys_clk(sys_clk), .reset(reset),
        .link(link.device), .core_cmd(core_cmd), .core_wake_src(core_wake_src), .field_detect(field_detect),
        .reply_ready(reply_ready), .mode_state(mode_state), .slow_oscillator(slow_oscillator),
        .fast_oscillator(fast_oscillator), .host_if_sel(host_if_sel), .spi_enabled(spi_enabled),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .read_started(read_started));
    npm_host #(.INIT_CYC(20), .WAKE_CYC(16), .SCK_DIV(8)) u_npm_host (.sys_clk(sys_clk), .reset(reset),
        .link(link.host), .wake_req(wake_req), .byte_req(byte_req), .byte_data(byte_data),
        .end_frame(end_frame), .busy(busy), .powered_wait_done(powered_wait_done), .irq_pending(irq_pending));
    // second device, wake pin driven by the bench to send a too-short pulse
    npm_device #(.WAKE_CYC(DEV_WAKE), .OSC_CYC(DEV_OSC)) u_npm_device_b (.sys_clk(sys_clk), .reset(reset),
        .link(link_b.device), .core_cmd(NPM_CMD_NONE), .core_wake_src(WAKE_SRC_PIN), .field_detect(1'b0),
        .reply_ready(1'b0), .mode_state(mode_b), .slow_oscillator(), .fast_oscillator(), .host_if_sel(),
        .spi_enabled(), .rx_byte(), .rx_valid(), .read_started());
    npm_link_props #(.OSC_CYC(DEV_OSC)) u_npm_link_props (.sys_clk(sys_clk), .reset(reset),
        .wake_n(link.wake_n), .spi_ss_n(link.spi_ss_n), .spi_miso_oe_n(link.spi_miso_oe_n),
        .irq_out_n(link.irq_out_n), .mode_state(mode_state), .slow_oscillator(slow_oscillator),
        .fast_oscillator(fast_oscillator), .spi_enabled(spi_enabled), .host_if_sel(host_if_sel));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (rx_valid === 1'b1) rx_count <= rx_count + 1;
    end
    // host-side view of the flag byte, taken on the rising sck edge
    always @(posedge link.spi_sck) begin
        miso_cap <= {miso_cap[6:0], link.spi_miso};
    end
    task automatic tick;
        @(posedge sys_clk);
        #2;
    endtask
    task automatic check(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic wait_mode(input npm_state_e s);
        for (int i = 0; i < 2000 && mode_state !== s; i++) tick;
    endtask
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) tick;
        byte_data = b;
        byte_req = 1'b1;
        tick;
        byte_req = 1'b0;
        tick;
        for (int i = 0; i < 400 && busy !== 1'b0; i++) tick;
    endtask
    // select must stay high a few cycles between frames
    task automatic close_frame;
        end_frame = 1'b1;
        tick;
        end_frame = 1'b0;
        repeat (8) tick;
    endtask
    task automatic pulse_cmd(input npm_cmd_e c);
        core_cmd = c;
        tick;
        core_cmd = NPM_CMD_NONE;
        repeat (3) tick;
    endtask
    task automatic host_wake;
        wake_req = 1'b1;
        tick;
        wake_req = 1'b0;
        wait_mode(NPM_READY);
    endtask
    task automatic pulse_b(input int n);
        link_b.wake_n = 1'b0;
        repeat (n) tick;
        link_b.wake_n = 1'b1;
        repeat (20) tick;
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge sys_clk);
        fail_count++;
        $display("wrong value at %0t: run hung", $time);
        wrap_up;
    end
    initial begin
        reset = 1'b1;
        {wake_req, byte_req, end_frame, field_detect, reply_ready} = '0;
        byte_data = 8'h00;
        core_cmd = NPM_CMD_NONE;
        core_wake_src = WAKE_SRC_PIN;
        link_b.wake_n = 1'b1;
        link_b.spi_ss_n = 1'b1;
        link_b.spi_sck = 1'b0;
        link_b.spi_mosi = 1'b0;
        link_b.host_if_select_0 = 1'b1;
        link_b.host_if_select_1 = 1'b0;
        repeat (5) tick;
        reset = 1'b0;
        tick;
        check(mode_state === NPM_POWER_UP && slow_oscillator === 1'b1, "not in power-up");
        check(link.wake_n === 1'b1 && link.irq_out_n === 1'b1, "link not idle");
        for (int i = 0; i < 200 && powered_wait_done !== 1'b1; i++) tick;
        send_byte(CTL_SEND);
        close_frame;
        check(rx_count === 0, "spi taken in power-up");
        host_wake;
        check(mode_state === NPM_READY && host_if_sel === IF_SEL_SPI, "startup failed");
        send_byte(CTL_SEND);
        send_byte(8'ha5);
        close_frame;
        check(rx_count === 2 && rx_byte === 8'ha5, "command byte lost");
        pulse_cmd(NPM_CMD_HIBERNATE);
        check(mode_state === NPM_HIBERNATE && spi_enabled === 1'b0, "no hibernate");
        field_detect = 1'b1;
        send_byte(CTL_SEND);
        close_frame;
        field_detect = 1'b0;
        check(mode_state === NPM_HIBERNATE && rx_count === 2, "hibernate disturbed");
        host_wake;
        check(mode_state === NPM_READY, "no wake from hibernate");
        core_wake_src = WAKE_SRC_FIELD;
        pulse_cmd(NPM_CMD_SLEEP);
        check(mode_state === NPM_SLEEP && slow_oscillator === 1'b1, "no sleep");
        field_detect = 1'b1;
        wait_mode(NPM_READY);
        field_detect = 1'b0;
        check(mode_state === NPM_READY, "field did not wake");
        core_wake_src = WAKE_SRC_PIN;
        pulse_cmd(NPM_CMD_SLEEP);
        host_wake;
        check(mode_state === NPM_READY, "pin did not wake");
        pulse_cmd(NPM_CMD_CHOOSE_PROTOCOL);
        check(mode_state === NPM_TAG_EMU, "no tag emulation");
        send_byte(CTL_POLL);
        send_byte(8'h00);
        close_frame;
        check(miso_cap === 8'h04, "poll flags wrong with no reply");
        reply_ready = 1'b1;
        tick;
        reply_ready = 1'b0;
        repeat (5) tick;
        check(link.irq_out_n === 1'b0 && irq_pending === 1'b1, "reply not flagged");
        send_byte(CTL_POLL);
        send_byte(8'h00);
        close_frame;
        check(miso_cap === 8'h08, "poll flags miss the reply");
        send_byte(CTL_READ);
        check(read_started === 1'b1 && link.irq_out_n === 1'b0, "interrupt dropped early");
        close_frame;
        check(link.irq_out_n === 1'b1, "interrupt held after read");
        pulse_cmd(NPM_CMD_END_EMU);
        check(mode_state === NPM_READY, "emulation not left");
        send_byte(CTL_RESET);
        check(mode_state === NPM_READY, "reset while selected");
        close_frame;
        check(mode_state === NPM_POWER_UP, "spi reset ignored");
        pulse_b(DEV_WAKE - 2);
        check(mode_b === NPM_POWER_UP, "short pulse woke device");
        pulse_b(DEV_WAKE + 6);
        for (int i = 0; i < 200 && mode_b !== NPM_READY; i++) tick;
        check(mode_b === NPM_READY, "long pulse did not wake");
        wrap_up;
    end
endmodule
`default_nettype wire
